// ==== rtl/fifo_ctrl.sv ====
`timescale 1ns/10ps
module fifo_ctrl
	import fifo_cascade_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic [AVS_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [AVS_DATA_W-1:0] avs_writedata,
	output logic      [AVS_DATA_W-1:0] avs_readdata,
	output logic                       avs_waitrequest,
	fifo_link_if.ctl                   link
);
	import fifo_cascade_pkg::*;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_reg;
	logic              in_reset;
	logic              fall;
	logic              sel_wr;
	logic              sel_rd;
	logic              space_ok;
	logic              valid_ok;
	logic              wr_go;
	logic              wr_done;
	logic              rd_fall;
	logic              rd_std;
	logic              rd_done;
	logic              write_n_reg;
	logic [DATA_W-1:0] wdata_reg;
	rd_state_e         state_reg;

	assign in_reset = ctrl_reg[CTRL_RESET_BIT];
	assign fall     = ctrl_reg[CTRL_FALL_BIT];

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RST_VAL;
		end else if (avs_write && avs_address == REG_CTRL) begin
			ctrl_reg[CTRL_RESET_BIT] <= avs_writedata[CTRL_RESET_BIT];
			// Mode and the frequency select move only while the device is held
			if (in_reset) begin
				ctrl_reg[CTRL_FALL_BIT] <= avs_writedata[CTRL_FALL_BIT];
				ctrl_reg[CTRL_FREQ_BIT] <= avs_writedata[CTRL_FREQ_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Flag decode; one device, so composite equals its own flag
	// ----------------------------------------------------------------
	assign space_ok = fall ? !link.space_flag : link.space_flag;
	assign valid_ok = fall ? !link.data_flag : link.data_flag;

	// ----------------------------------------------------------------
	// Write path; one idle edge after each write lets the flag catch up
	// ----------------------------------------------------------------
	assign sel_wr  = avs_write && avs_address == REG_WR_DATA;
	assign wr_go   = sel_wr && !in_reset && space_ok && write_n_reg;
	assign wr_done = sel_wr && (in_reset || wr_go);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			write_n_reg <= 1'b1;
			wdata_reg   <= '0;
		end else begin
			write_n_reg <= !wr_go;
			if (wr_go) begin
				wdata_reg <= avs_writedata[DATA_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	assign sel_rd  = avs_read && avs_address == REG_RD_DATA;
	assign rd_fall = sel_rd && fall && !in_reset && valid_ok;
	assign rd_std  = sel_rd && !fall && !in_reset && valid_ok && state_reg == ST_IDLE;
	assign rd_done = sel_rd && (in_reset || rd_fall || state_reg == ST_DATA);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (rd_std) begin
						state_reg <= ST_DATA;
					end
				end
				ST_DATA: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.master_reset_n    = !in_reset;
	assign link.mode_fall_through = fall;
	assign link.frequency_select  = ctrl_reg[CTRL_FREQ_BIT];
	assign link.write_n           = write_n_reg;
	assign link.wdata             = wdata_reg;
	assign link.read_n            = !(rd_fall || rd_std);
	assign avs_waitrequest        = (sel_wr && !wr_done) || (sel_rd && !rd_done);

	always_comb begin
		avs_readdata = '0;
		unique case (avs_address)
			REG_RD_DATA: avs_readdata[DATA_W-1:0] = link.rdata;
			REG_STATUS: begin
				avs_readdata[STAT_HALF_BIT]  = link.half_full_n;
				avs_readdata[STAT_SPACE_BIT] = link.space_flag;
				avs_readdata[STAT_DATA_BIT]  = link.data_flag;
			end
			REG_CTRL:    avs_readdata[CTRL_W-1:0] = ctrl_reg;
			default:     avs_readdata = '0;
		endcase
	end
endmodule : fifo_ctrl

// ==== pkg/fifo_cascade_pkg.sv ====
package fifo_cascade_pkg;
	// ----------------------------------------------------------------
	// Storage shape
	// ----------------------------------------------------------------
	localparam int                DATA_W = 9;
	localparam int                PTR_W  = 14;
	localparam int                CNT_W  = 15;
	localparam logic [CNT_W-1:0]  DEPTH  = 15'h4000;
	localparam logic [CNT_W-1:0]  HALF   = 15'h2000;
	localparam logic [CNT_W-1:0]  CNT_ONE = 15'h0001;

	// ----------------------------------------------------------------
	// Fixed latency, figures in ns and derived clock counts
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SETTLE_NS       = 60;
	localparam int SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Controller register map (Avalon-MM, byte addresses)
	// ----------------------------------------------------------------
	localparam int               AVS_ADDR_W = 4;
	localparam int               AVS_DATA_W = 32;
	localparam logic [AVS_ADDR_W-1:0] REG_WR_DATA = 4'h0;
	localparam logic [AVS_ADDR_W-1:0] REG_RD_DATA = 4'h4;
	localparam logic [AVS_ADDR_W-1:0] REG_STATUS  = 4'h8;
	localparam logic [AVS_ADDR_W-1:0] REG_CTRL    = 4'hc;

	localparam int             CTRL_W          = 3;
	localparam int             CTRL_FALL_BIT   = 0;
	localparam int             CTRL_RESET_BIT  = 1;
	localparam int             CTRL_FREQ_BIT   = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 3'h2;

	localparam int STAT_HALF_BIT  = 0;
	localparam int STAT_SPACE_BIT = 1;
	localparam int STAT_DATA_BIT  = 2;
	localparam int STAT_W         = 3;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_DATA = 1'b1
	} rd_state_e;
endpackage : fifo_cascade_pkg

// ==== pkg/fifo_link_if.sv ====
`timescale 1ns/10ps
interface fifo_link_if;
	import fifo_cascade_pkg::*;
	logic              master_reset_n;
	logic              mode_fall_through;
	logic              frequency_select;
	logic              write_n;
	logic [DATA_W-1:0] wdata;
	logic              read_n;
	logic [DATA_W-1:0] rdata;
	logic              space_flag;
	logic              data_flag;
	logic              half_full_n;

	modport dev (
		input  master_reset_n, mode_fall_through, frequency_select,
		input  write_n, wdata, read_n,
		output rdata, space_flag, data_flag, half_full_n
	);
	modport ctl (
		output master_reset_n, mode_fall_through, frequency_select,
		output write_n, wdata, read_n,
		input  rdata, space_flag, data_flag, half_full_n
	);
endinterface : fifo_link_if

// ==== rtl/fifo_stage.sv ====
`timescale 1ns/10ps
module fifo_stage
	import fifo_cascade_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	fifo_link_if.dev  link
);
	import fifo_cascade_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0]  wptr_reg;
	logic [PTR_W-1:0]  rptr_reg;
	logic [CNT_W-1:0]  count_reg;
	logic              mode_reg;
	logic              out_valid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [CNT_W-1:0]  total;
	logic              mem_full;
	logic              mem_empty;
	logic              wr_go;
	logic              rd_std;
	logic              load;
	logic              pop;
	logic              run;

	assign run       = link.master_reset_n;
	assign mem_full  = (count_reg == DEPTH);
	assign mem_empty = (count_reg == '0);
	assign wr_go     = run && !link.write_n && !mem_full;
	assign rd_std    = run && !mode_reg && !link.read_n && !mem_empty;
	// Output register refills by itself: no read needed for the first word
	assign load      = run && mode_reg && !mem_empty && (!out_valid_reg || !link.read_n);
	assign pop       = rd_std || load;
	assign total     = count_reg + {{(CNT_W-1){1'b0}}, out_valid_reg};

	// ----------------------------------------------------------------
	// Mode capture, only while held in master reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= 1'b0;
		end else if (!link.master_reset_n) begin
			mode_reg <= link.mode_fall_through;
		end
	end

	// ----------------------------------------------------------------
	// Storage; the array has no reset so it maps to block memory
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (wr_go) begin
			mem[wptr_reg] <= link.wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else if (!run) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (wr_go) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= '0;
		end else if (!run) begin
			count_reg <= '0;
		end else if (wr_go && !pop) begin
			count_reg <= count_reg + CNT_ONE;
		end else if (pop && !wr_go) begin
			count_reg <= count_reg - CNT_ONE;
		end
	end

	// ----------------------------------------------------------------
	// Output stage; fixed two-edge latency from write strobe to valid (store edge, then load edge)
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid_reg <= 1'b0;
		end else if (!run) begin
			out_valid_reg <= 1'b0;
		end else if (load) begin
			out_valid_reg <= 1'b1;
		end else if (mode_reg && !link.read_n) begin
			out_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= '0;
		end else if (pop) begin
			rdata_reg <= mem[rptr_reg];
		end
	end

	// ----------------------------------------------------------------
	// Flags, all from registers, so one clock and no crossing hazard
	// ----------------------------------------------------------------
	assign link.rdata       = rdata_reg;
	// In fall-through mode low on a valid word, which doubles as the next stage's write enable
	assign link.data_flag   = mode_reg ? !out_valid_reg : !mem_empty;
	// In fall-through mode low when a slot is free, so the slot walks back up the chain
	assign link.space_flag  = mode_reg ? mem_full : !mem_full;
	assign link.half_full_n = !(total > HALF);
endmodule : fifo_stage

// ==== verification/fifo_link_sva.sv ====
`timescale 1ns/10ps
module fifo_link_sva
	import fifo_cascade_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	input wire logic              master_reset_n,
	input wire logic              mode_fall_through,
	input wire logic              frequency_select,
	input wire logic              write_n,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              read_n,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              space_flag,
	input wire logic              data_flag,
	input wire logic              half_full_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// --------------------------------
	// Link sequences
	// --------------------------------
	sequence s_store;
		master_reset_n && !write_n;
	endsequence
	sequence s_held_std;
		(!master_reset_n && !mode_fall_through)[*3];
	endsequence
	// --------------------------------
	// Link properties
	// --------------------------------
	a_ft_first_word: assert property (
		s_store ##0 (mode_fall_through && data_flag) |-> ##[1:3] !data_flag)
		else $error("first word did not fall through");
	a_std_first_word: assert property (
		s_store ##0 (!mode_fall_through && !data_flag) |-> ##[1:3] data_flag)
		else $error("empty flag did not clear after store");
	a_hold_word: assert property (
		master_reset_n && mode_fall_through && !data_flag && read_n
		|=> (!data_flag && $stable(rdata)) || !master_reset_n)
		else $error("unread word changed");
	a_read_when_valid: assert property (
		!read_n |-> master_reset_n && (mode_fall_through ? !data_flag : data_flag))
		else $error("read issued without data");
	a_write_pulse: assert property (!write_n |=> write_n)
		else $error("write strobe longer than one cycle");
	a_write_space: assert property (
		!write_n |-> ($past(space_flag) ^ $past(mode_fall_through)))
		else $error("write issued without space");
	a_reset_empty: assert property (
		s_held_std |-> !data_flag && space_flag && half_full_n)
		else $error("flags not cleared by master reset");
	a_mode_fixed: assert property (
		master_reset_n && $past(master_reset_n)
		|-> $stable(frequency_select) && $stable(mode_fall_through))
		else $error("mode or select moved while running");
	a_half_cause: assert property (
		$fell(half_full_n) |-> !$past(write_n) || !$past(write_n, 2))
		else $error("half flag fell without a write");
endmodule : fifo_link_sva

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import fifo_cascade_pkg::*;
	logic                  clk_sys = 1'b0;
	logic                  sys_rst = 1'b1;
	logic [AVS_ADDR_W-1:0] avs_address = '0;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [AVS_DATA_W-1:0] avs_writedata = '0;
	logic [AVS_DATA_W-1:0] avs_readdata;
	logic                  avs_waitrequest;
	int                    n_mismatch = 0;
	int                    samples_checked = 0;

	fifo_link_if link ();
	fifo_ctrl fifo_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
	fifo_stage fifo_stage_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link));
	fifo_link_sva fifo_link_sva_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.master_reset_n(link.master_reset_n), .mode_fall_through(link.mode_fall_through),
		.frequency_select(link.frequency_select), .write_n(link.write_n),
		.wdata(link.wdata), .read_n(link.read_n), .rdata(link.rdata),
		.space_flag(link.space_flag), .data_flag(link.data_flag),
		.half_full_n(link.half_full_n));

	always #5 clk_sys = ~clk_sys;

	// --------------------------------
	// Bus, check and close-out tasks
	// --------------------------------
	task close_out;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [AVS_DATA_W-1:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Waitrequest is sampled at the edge itself, before that edge's updates land
	task av_wr(input logic [AVS_ADDR_W-1:0] a, input logic [AVS_DATA_W-1:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_write     <= 1'b1;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : av_wr

	task av_rd(input logic [AVS_ADDR_W-1:0] a, input logic [AVS_DATA_W-1:0] exp,
		input string nm);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		chk(nm, avs_readdata, exp);
		avs_read <= 1'b0;
	endtask : av_rd

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		av_rd(REG_CTRL, 32'h0000_0002, "ctrl_reset");
		av_rd(REG_STATUS, 32'h0000_0003, "stat_reset");
		av_wr(4'h1, 32'h0000_01ff);
		av_rd(4'h1, 32'h0000_0000, "unmapped");
		av_wr(REG_CTRL, 32'h0000_0000);
		av_wr(REG_WR_DATA, 32'hffff_fe5a);
		av_wr(REG_WR_DATA, 32'h0000_01ff);
		av_wr(REG_WR_DATA, 32'h0000_0100);
		av_rd(REG_RD_DATA, 32'h0000_005a, "std_word0");
		av_rd(REG_RD_DATA, 32'h0000_01ff, "std_word1");
		av_rd(REG_RD_DATA, 32'h0000_0100, "std_word2");
		av_rd(REG_STATUS, 32'h0000_0003, "stat_std_empty");
		// Mode may only move while the device is held in master reset
		av_wr(REG_CTRL, 32'h0000_0002);
		av_wr(REG_CTRL, 32'h0000_0007);
		av_wr(REG_CTRL, 32'h0000_0005);
		av_rd(REG_CTRL, 32'h0000_0005, "ctrl_ft");
		av_rd(REG_STATUS, 32'h0000_0005, "stat_ft_empty");
		for (int i = 0; i < 8193; i++) begin
			if (i == 8192)
				av_rd(REG_STATUS, 32'h0000_0001, "half_edge");
			av_wr(REG_WR_DATA, 32'(i));
		end
		av_rd(REG_STATUS, 32'h0000_0000, "half_set");
		for (int i = 0; i < 8193; i++)
			av_rd(REG_RD_DATA, {23'h0, 9'(i)}, "ft_word");
		av_rd(REG_STATUS, 32'h0000_0005, "stat_ft_drain");
		close_out();
	end

	// Roughly 33k cycles expected; the margin covers slow data handshakes
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_mismatch++;
		close_out();
	end
endmodule : tb_top
